// ===== hw/adc_channel_calibration_regs.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps
module adc_channel_calibration_regs (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RESET,
  // Register port
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output      logic [15:0] O_RDATA,
  // Global filter setting for channel 2
  input  wire logic        I_GLOBAL_HIGHPASS_SETTING,
  // Calibration words to the datapath
  output      logic signed [23:0] O_CH1_OFFSET,
  output      logic [23:0] O_CH1_GAIN,
  output      logic signed [23:0] O_CH2_OFFSET,
  // Channel 2 configuration to the datapath
  output      logic signed [9:0] O_CH2_DELAY_ADJUST,
  output      logic        O_CH2_HIGHPASS_EN,
  output      logic [1:0]  O_CH2_INPUT_SELECT
);

  typedef struct packed {
    cal_regs_pkg::ch_cfg_t cfg;
    logic [15:0]           rdata;
  } state_t;

  state_t state;
  state_t next_state;
  cal_regs_pkg::bus_req_t req;
  cal_regs_pkg::cal_word_t ch1_ofs;
  cal_regs_pkg::cal_word_t ch1_gain;
  cal_regs_pkg::cal_word_t ch2_ofs;
  logic [15:0] ch1_ofs_hi;
  logic [15:0] ch1_ofs_lo;
  logic [15:0] ch1_gain_hi;
  logic [15:0] ch1_gain_lo;
  logic [15:0] ch2_ofs_hi;
  logic [15:0] ch2_ofs_lo;

  assign req = '{wr: I_WR, rd: I_RD, addr: I_ADDR, wdata: I_WDATA};

  cal_word_reg #(
    .ADDR_HI (cal_regs_pkg::ADDR_CH1_OFS_HI),
    .ADDR_LO (cal_regs_pkg::ADDR_CH1_OFS_LO),
    .RST_HI  (cal_regs_pkg::RST_OFS_HI),
    .RST_LO  (cal_regs_pkg::RST_OFS_LO)
  ) u_ch1_ofs (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_req   (req),
    .o_word  (ch1_ofs),
    .o_hi    (ch1_ofs_hi),
    .o_lo    (ch1_ofs_lo)
  );

  cal_word_reg #(
    .ADDR_HI (cal_regs_pkg::ADDR_CH1_GAIN_HI),
    .ADDR_LO (cal_regs_pkg::ADDR_CH1_GAIN_LO),
    .RST_HI  (cal_regs_pkg::RST_GAIN_HI),
    .RST_LO  (cal_regs_pkg::RST_GAIN_LO)
  ) u_ch1_gain (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_req   (req),
    .o_word  (ch1_gain),
    .o_hi    (ch1_gain_hi),
    .o_lo    (ch1_gain_lo)
  );

  cal_word_reg #(
    .ADDR_HI (cal_regs_pkg::ADDR_CH2_OFS_HI),
    .ADDR_LO (cal_regs_pkg::ADDR_CH2_OFS_LO),
    .RST_HI  (cal_regs_pkg::RST_OFS_HI),
    .RST_LO  (cal_regs_pkg::RST_OFS_LO)
  ) u_ch2_ofs (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_req   (req),
    .o_word  (ch2_ofs),
    .o_hi    (ch2_ofs_hi),
    .o_lo    (ch2_ofs_lo)
  );

  function automatic logic [15:0] cfg_image(input cal_regs_pkg::ch_cfg_t c);
    cfg_image = {c.delay_adjust, cal_regs_pkg::RSVD_CFG, c.highpass_bypass,
                 c.input_select};
  endfunction

  always_comb begin
    next_state = state;
    if (req.wr && req.addr == cal_regs_pkg::ADDR_CH2_CONFIG) begin
      next_state.cfg.delay_adjust =
        req.wdata[cal_regs_pkg::CFG_DELAY_MSB:cal_regs_pkg::CFG_DELAY_LSB];
      next_state.cfg.highpass_bypass = req.wdata[cal_regs_pkg::CFG_BYPASS_BIT];
      next_state.cfg.input_select = cal_regs_pkg::input_sel_t'(
        req.wdata[cal_regs_pkg::CFG_SEL_MSB:cal_regs_pkg::CFG_SEL_LSB]);
    end
    // Unmapped addresses and idle cycles read as zero
    next_state.rdata = cal_regs_pkg::READ_ZERO;
    if (req.rd) begin
      case (req.addr)
        cal_regs_pkg::ADDR_CH1_OFS_HI:  next_state.rdata = ch1_ofs_hi;
        cal_regs_pkg::ADDR_CH1_OFS_LO:  next_state.rdata = ch1_ofs_lo;
        cal_regs_pkg::ADDR_CH1_GAIN_HI: next_state.rdata = ch1_gain_hi;
        cal_regs_pkg::ADDR_CH1_GAIN_LO: next_state.rdata = ch1_gain_lo;
        cal_regs_pkg::ADDR_CH2_CONFIG:     next_state.rdata = cfg_image(state.cfg);
        cal_regs_pkg::ADDR_CH2_OFS_HI:  next_state.rdata = ch2_ofs_hi;
        cal_regs_pkg::ADDR_CH2_OFS_LO:  next_state.rdata = ch2_ofs_lo;
        default:                        next_state.rdata = cal_regs_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      state.cfg   <= cal_regs_pkg::ch_cfg_t'({
        cal_regs_pkg::RST_CFG[cal_regs_pkg::CFG_DELAY_MSB:cal_regs_pkg::CFG_DELAY_LSB],
        cal_regs_pkg::RST_CFG[cal_regs_pkg::CFG_BYPASS_BIT:cal_regs_pkg::CFG_SEL_LSB]});
      state.rdata <= cal_regs_pkg::READ_ZERO;
    end else begin
      state <= next_state;
    end
  end

  assign O_RDATA            = state.rdata;
  assign O_CH1_OFFSET       = $signed(ch1_ofs);
  // Unsigned gain, 8000_00h is unity; full scale just under two
  assign O_CH1_GAIN         = ch1_gain;
  assign O_CH2_OFFSET       = $signed(ch2_ofs);
  assign O_CH2_DELAY_ADJUST = $signed(state.cfg.delay_adjust);
  // Bypass overrides; with bypass clear the global setting decides
  assign O_CH2_HIGHPASS_EN  = !state.cfg.highpass_bypass && I_GLOBAL_HIGHPASS_SETTING;
  assign O_CH2_INPUT_SELECT = state.cfg.input_select;

endmodule

// ===== hw/cal_regs_pkg.sv
package cal_regs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  localparam logic [ADDR_W-1:0] ADDR_CH1_OFS_HI  = 8'h0f;
  localparam logic [ADDR_W-1:0] ADDR_CH1_OFS_LO  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CH1_GAIN_HI = 8'h11;
  localparam logic [ADDR_W-1:0] ADDR_CH1_GAIN_LO = 8'h12;
  localparam logic [ADDR_W-1:0] ADDR_CH2_CONFIG     = 8'h13;
  localparam logic [ADDR_W-1:0] ADDR_CH2_OFS_HI  = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_CH2_OFS_LO  = 8'h15;

  localparam logic [DATA_W-1:0] RST_OFS_HI  = 16'h0000;
  localparam logic [7:0]        RST_OFS_LO  = 8'h00;
  localparam logic [DATA_W-1:0] RST_GAIN_HI = 16'h8000;
  localparam logic [7:0]        RST_GAIN_LO = 8'h00;
  localparam logic [DATA_W-1:0] RST_CFG     = 16'h0000;
  localparam logic [7:0]        RSVD_BYTE   = 8'h00;
  localparam logic [2:0]        RSVD_CFG    = 3'h0;
  localparam logic [DATA_W-1:0] READ_ZERO   = 16'h0000;

  // Field positions
  localparam int LO_FIELD_MSB    = 15;
  localparam int LO_FIELD_LSB    = 8;
  localparam int CFG_DELAY_MSB   = 15;
  localparam int CFG_DELAY_LSB   = 6;
  localparam int CFG_BYPASS_BIT  = 2;
  localparam int CFG_SEL_MSB     = 1;
  localparam int CFG_SEL_LSB     = 0;

  typedef enum logic [1:0] {
    SEL_PAIR     = 2'b00,
    SEL_SHORTED  = 2'b01,
    SEL_TEST_POS = 2'b10,
    SEL_TEST_NEG = 2'b11
  } input_sel_t;

  typedef struct packed {
    logic [9:0] delay_adjust;
    logic       highpass_bypass;
    input_sel_t input_select;
  } ch_cfg_t;

  typedef struct packed {
    logic [DATA_W-1:0] upper;
    logic [7:0]        lower;
  } cal_word_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

endpackage

// ===== hw/cal_word_reg.sv
`timescale 1ns/1ps
// One 24-bit calibration word spread over a high and a low register
module cal_word_reg #(
  parameter logic [7:0]  ADDR_HI = 8'h00,
  parameter logic [7:0]  ADDR_LO = 8'h00,
  parameter logic [15:0] RST_HI  = 16'h0000,
  parameter logic [7:0]  RST_LO  = 8'h00
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_reset,
  // Register bus
  input  wire cal_regs_pkg::bus_req_t i_req,
  // Word out and read-back
  output      cal_regs_pkg::cal_word_t o_word,
  output      logic [15:0]           o_hi,
  output      logic [15:0]           o_lo
);

  cal_regs_pkg::cal_word_t state;
  cal_regs_pkg::cal_word_t next_state;

  always_comb begin
    next_state = state;
    if (i_req.wr && i_req.addr == ADDR_HI) begin
      next_state.upper = i_req.wdata;
    end
    if (i_req.wr && i_req.addr == ADDR_LO) begin
      next_state.lower = i_req.wdata[cal_regs_pkg::LO_FIELD_MSB:cal_regs_pkg::LO_FIELD_LSB];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state <= '{upper: RST_HI, lower: RST_LO};
    end else begin
      state <= next_state;
    end
  end

  assign o_word = state;
  assign o_hi   = state.upper;
  assign o_lo   = {state.lower, cal_regs_pkg::RSVD_BYTE};

endmodule

// ===== bench/cal_regs_checker.sv
`timescale 1ns/1ps
module cal_regs_checker (
  input wire logic I_CLK, I_RESET, I_WR, I_RD, I_GLOBAL_HIGHPASS_SETTING,
  input wire logic [7:0] I_ADDR,
  input wire logic [15:0] I_WDATA, O_RDATA,
  input wire logic signed [23:0] O_CH1_OFFSET, O_CH2_OFFSET,
  input wire logic [23:0] O_CH1_GAIN,
  input wire logic signed [9:0] O_CH2_DELAY_ADJUST,
  input wire logic O_CH2_HIGHPASS_EN,
  input wire logic [1:0] O_CH2_INPUT_SELECT
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  AST_RD_IDLE: assert property (!I_RD |=> O_RDATA == 16'h0000)
    else $error("read data not idle");
  AST_OFS1_HI: assert property (I_WR && I_ADDR == 8'h0f |=> O_CH1_OFFSET[23:8] == $past(I_WDATA))
    else $error("ch1 offset high");
  AST_OFS2_LO: assert property (I_WR && I_ADDR == 8'h15 |=> O_CH2_OFFSET[7:0] == $past(I_WDATA[15:8]))
    else $error("ch2 offset low");
  AST_GAIN_HI: assert property (I_WR && I_ADDR == 8'h11 |=> O_CH1_GAIN[23:8] == $past(I_WDATA))
    else $error("ch1 gain high");
  AST_CFG: assert property (I_WR && I_ADDR == 8'h13 |=> O_CH2_DELAY_ADJUST == $past(I_WDATA[15:6])
    && O_CH2_INPUT_SELECT == $past(I_WDATA[1:0])) else $error("ch2 config");
  AST_HPF: assert property (!I_GLOBAL_HIGHPASS_SETTING |-> !O_CH2_HIGHPASS_EN)
    else $error("highpass without global");
  AST_RSVD_LO: assert property (I_RD && I_ADDR inside {8'h10, 8'h12, 8'h15} |=> O_RDATA[7:0] == 8'h00)
    else $error("low byte not zero");
  AST_RSVD_CFG: assert property (I_RD && I_ADDR == 8'h13 |=> O_RDATA[5:3] == 3'b000)
    else $error("config bits 5:3 not zero");
  cover property (I_WR && I_ADDR == 8'h13);
  cover property (I_RD ##1 O_RDATA != 16'h0000);
  cover property (O_CH2_HIGHPASS_EN);
endmodule
bind adc_channel_calibration_regs cal_regs_checker u_chk (.*);

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic I_CLK = 0, I_RESET = 1, I_WR = 0, I_RD = 0, I_GLOBAL_HIGHPASS_SETTING = 0;
  logic [7:0] I_ADDR = 8'h00, a;
  logic [15:0] I_WDATA = 16'h0000, O_RDATA, d;
  logic signed [23:0] O_CH1_OFFSET, O_CH2_OFFSET;
  logic [23:0] O_CH1_GAIN;
  logic signed [9:0] O_CH2_DELAY_ADJUST;
  logic O_CH2_HIGHPASS_EN;
  logic [1:0] O_CH2_INPUT_SELECT;
  logic [15:0] m [8'h0f:8'h15];
  int errors = 0, compares = 0;
  adc_channel_calibration_regs uut (.*);
  initial forever #2 I_CLK = ~I_CLK;
  function automatic logic [15:0] msk(input logic [7:0] ad, input logic [15:0] v);
    case (ad)
      8'h10, 8'h12, 8'h15: return v & 16'hff00;
      8'h13: return v & 16'hffc7;
      default: return v;
    endcase
  endfunction
  task automatic check(input string n, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic do_reset;
    I_RESET <= 1;
    repeat (6) @(posedge I_CLK);
    I_RESET <= 0;
    foreach (m[i]) m[i] = 16'h0000;
    m[8'h11] = 16'h8000;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [15:0] v);
    I_WR <= 1;
    I_ADDR <= ad;
    I_WDATA <= v;
    @(posedge I_CLK);
    I_WR <= 0;
    if (ad inside {[8'h0f:8'h15]}) m[ad] = msk(ad, v);
    // One idle edge so the next strobe is never assigned in this time step
    @(posedge I_CLK);
  endtask
  // Read data is looked at mid-cycle, while it stands
  task automatic rd(input logic [7:0] ad);
    I_RD <= 1;
    I_ADDR <= ad;
    @(posedge I_CLK);
    I_RD <= 0;
    @(negedge I_CLK);
    check("rdata", (ad inside {[8'h0f:8'h15]}) ? m[ad] : 16'h0000, O_RDATA);
    @(posedge I_CLK);
  endtask
  task automatic outs;
    check("ch1_ofs", {m[8'h0f], m[8'h10][15:8]}, O_CH1_OFFSET);
    check("ch1_gain", {m[8'h11], m[8'h12][15:8]}, O_CH1_GAIN);
    check("ch2_ofs", {m[8'h14], m[8'h15][15:8]}, O_CH2_OFFSET);
    check("ch2_config", {m[8'h13][15:6], m[8'h13][1:0]}, {O_CH2_DELAY_ADJUST, O_CH2_INPUT_SELECT});
    check("hpf", I_GLOBAL_HIGHPASS_SETTING & ~m[8'h13][2], O_CH2_HIGHPASS_EN);
  endtask
  initial begin
    repeat (20000) @(posedge I_CLK);
    errors++;
    finish_test;
  end
  initial begin
    void'($urandom(92281));
    do_reset;
    for (int i = 8'h0e; i <= 8'h16; i++) rd(8'(i));
    outs;
    $display("done reset_values");
    repeat (60) begin
      a = 8'h0e + 8'($urandom_range(8));
      d = 16'($urandom);
      I_GLOBAL_HIGHPASS_SETTING <= 1'($urandom);
      wr(a, d);
      rd(a);
      outs;
    end
    $display("done random_access");
    // Most negative delay with every select code, bypass and global level
    for (int s = 0; s < 8; s++) begin
      I_GLOBAL_HIGHPASS_SETTING <= s[0];
      wr(8'h13, {10'h200, 3'b111, 3'(s)});
      rd(8'h13);
      outs;
    end
    $display("done ch2_config");
    for (int i = 8'h0f; i <= 8'h15; i++) wr(8'(i), 16'hffff);
    rd(8'h12);
    outs;
    $display("done full_scale");
    do_reset;
    rd(8'h11);
    outs;
    $display("done second_reset");
    finish_test;
  end
endmodule
